// ===== src/acf_pkg.sv
// acf_pkg: register map, field positions and reset values of the
// auxiliary control and interrupt flag block.
// assumes a 4-bit register select and an 8-bit data path.
package acf_pkg;
    // register select offsets
    localparam logic [3:0] OFS_PORT_B      = 4'h0; // port_b_output_register / latch read
    localparam logic [3:0] OFS_PORT_A      = 4'h1; // port_a_output_register / latch read
    localparam logic [3:0] OFS_DIR_B       = 4'h2; // port b direction, 1 = output
    localparam logic [3:0] OFS_DIR_A       = 4'h3; // port a direction, 1 = output
    localparam logic [3:0] OFS_T1_CNT_LO   = 4'h4; // timer_one counter low / latch low
    localparam logic [3:0] OFS_T1_CNT_HI   = 4'h5; // timer_one counter high, starts count
    localparam logic [3:0] OFS_T1_LAT_LO   = 4'h6; // timer_one latch low
    localparam logic [3:0] OFS_T1_LAT_HI   = 4'h7; // timer_one latch high
    localparam logic [3:0] OFS_AUX_CONTROL = 4'hb; // auxiliary_control
    localparam logic [3:0] OFS_IRQ_FLAGS   = 4'hd; // interrupt_flags
    localparam logic [3:0] OFS_IRQ_ENABLES = 4'he; // interrupt_enables
    // auxiliary_control fields
    localparam int ACB_PA_LATCH   = 0;
    localparam int ACB_PB_LATCH   = 1;
    localparam int ACB_SHIFT_LO   = 2; // shifter_mode_low_bit
    localparam int ACB_SHIFT_HI   = 4; // shifter_mode_high_bit
    localparam int ACB_T2_MODE    = 5; // timer_two_mode_bit
    localparam int ACB_T1_FREE    = 6; // timer_one_free_run_bit
    localparam int ACB_T1_OUT     = 7; // timer_one_output_enable_bit
    // interrupt flag positions
    localparam int IFB_A_SECOND   = 0;
    localparam int IFB_A_STROBE   = 1;
    localparam int IFB_SHIFTER    = 2;
    localparam int IFB_B_SECOND   = 3;
    localparam int IFB_B_STROBE   = 4;
    localparam int IFB_TIMER_TWO  = 5;
    localparam int IFB_TIMER_ONE  = 6;
    localparam int IFB_ANY        = 7; // set-control bit on enables write
    localparam int IRQ_SOURCES    = 7;
    // reset values
    localparam logic [7:0]  AUX_CONTROL_RST = 8'h00;
    localparam logic [6:0]  IRQ_FLAGS_RST   = 7'h00;
    localparam logic [6:0]  IRQ_ENABLES_RST = 7'h00;
    localparam logic [7:0]  PORT_RST        = 8'h00;
    localparam logic [15:0] TIMER_RST       = 16'h0000;
endpackage

// ===== src/acf_port_latch.sv
// acf_port_latch: input latch of one peripheral port.
// assumes pin levels are already synchronised to clock.
`timescale 1ns/1ns
`default_nettype none
module acf_port_latch
    import acf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       latch_enable, // latching mode on
    input  wire logic       capture,      // strobe flag being set now
    input  wire logic       hold,         // strobe flag is set
    input  wire logic [7:0] pin_level,    // synchronised pins
    input  wire logic [7:0] out_level,    // output register
    input  wire logic [7:0] direction,    // 1 = output pin
    output logic      [7:0] latched       // value seen by reads
);
    logic [7:0] latched_r;   // latch storage
    logic [7:0] latched_nxt; // next latch value
    logic [7:0] source;      // pin for inputs, output register for outputs

    // next latch value: transparent, capture or hold
    always_comb
    begin
        source = (pin_level & ~direction) | (out_level & direction);
        latched_nxt = source;
        if (latch_enable && !capture && hold)
        begin
            // flag already set: pins may move, latch stays
            latched_nxt = latched_r;
        end
    end

    // register only
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            latched_r <= PORT_RST;
        else
            latched_r <= latched_nxt;
    end

    assign latched = latched_r;
endmodule
`default_nettype wire

// ===== src/acf_aux_control_irq_flags.sv
// acf_aux_control_irq_flags: auxiliary control register, port input
// latches, timer_one, interrupt flags/enables and the request output.
// assumes a single 250 MHz clock; register accesses are one-cycle strobes.
// Function
// - capture port a when strobe flag sets
// - control bit 0 enables port a latching
// - port a read returns latch, not output
// - bit 1 latches port b, outputs use register
// - bits 4..2 select serial shifter mode
// - bit 5 selects timer two pulse counting
// - bit 6 free-run, bit 7 drives line seven
// - seven flags merge into one request
// - edge flags set regardless of enables
// - flag write clears bits written one
// - clear never loses a flag being set
// - free-run reloads counter from latches
// - latch writes leave running countdown alone
// - port a latching works with all modes
// - enable write with bit 7 sets enables
`timescale 1ns/1ns
`default_nettype none
module acf_aux_control_irq_flags
    import acf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       chip_select,     // access strobe, one cycle
    input  wire logic [3:0] reg_select,      // register offset
    input  wire logic       read_not_write,  // 1 = read
    input  wire logic [7:0] write_data,
    output logic      [7:0] read_data,       // valid one cycle after a read
    output logic            irq_n,           // active low request
    input  wire logic [7:0] port_a_in,       // pins, asynchronous
    output logic      [7:0] port_a_out,
    output logic      [7:0] port_a_oe,
    input  wire logic [7:0] port_b_in,       // pins, asynchronous
    output logic      [7:0] port_b_out,
    output logic      [7:0] port_b_oe,
    input  wire logic       port_a_strobe_input,        // pin
    input  wire logic       port_a_second_control_line, // pin, input modes
    input  wire logic       port_b_strobe_input,        // pin
    input  wire logic       port_b_second_control_line, // pin, input modes
    input  wire logic [3:0] edge_polarity,   // 1 = rising; a1, a2, b1, b2
    input  wire logic       shifter_done,    // same-clock event
    input  wire logic       timer_two_done,  // same-clock event
    output logic      [2:0] serial_shifter_mode,
    output logic            timer_two_count_pulses
);
    // three-stage synchroniser: stable value moves once stages 2 and 3 agree
    function automatic logic [7:0] agree(input logic [7:0] s2, input logic [7:0] s3,
                                         input logic [7:0] stable);
        agree = (s2 == s3) ? s3 : stable;
    endfunction

    // active edge of a stable control line
    function automatic logic edge_hit(input logic old_v, input logic new_v, input logic pol);
        edge_hit = (old_v != new_v) && (new_v == pol);
    endfunction

    logic [7:0]  s1_r, s2_r, s3_r, pa_st_r;     // port a sync chain + stable
    logic [7:0]  t1_r, t2_r, t3_r, pb_st_r;     // port b sync chain + stable
    logic [3:0]  c1_r, c2_r, c3_r, c_st_r;      // control line sync + stable
    logic [7:0]  pa_st_nxt, pb_st_nxt;
    logic [3:0]  c_st_nxt;
    logic [7:0]  ora_r, orb_r, dira_r, dirb_r;  // output and direction regs
    logic [7:0]  ora_nxt, orb_nxt, dira_nxt, dirb_nxt;
    logic [7:0]  acr_r, acr_nxt;                 // auxiliary_control
    logic [6:0]  ifr_r, ifr_nxt, ier_r, ier_nxt; // flags, enables
    logic [6:0]  set_ev;                          // flag set events this cycle
    logic [15:0] cnt_r, cnt_nxt, lat_r, lat_nxt;  // timer_one counter, latches
    logic        armed_r, armed_nxt;              // one-shot may still fire
    logic        pb7_r, pb7_nxt;                  // timer_one waveform level
    logic        timeout;                         // counter at zero
    logic [7:0]  rd_r, rd_nxt;                    // registered read data
    logic        irq_n_r, irq_n_nxt;
    logic [7:0]  pbo_r, pbo_nxt, pboe_r, pboe_nxt; // port b drive after override
    logic [7:0]  pa_latch, pb_latch;               // latch outputs
    logic        wr, rd;

    assign wr = chip_select && !read_not_write;
    assign rd = chip_select && read_not_write;

    // stable pin values; stage 1 only feeds stage 2
    always_comb
    begin
        pa_st_nxt = agree(s2_r, s3_r, pa_st_r);
        pb_st_nxt = agree(t2_r, t3_r, pb_st_r);
        c_st_nxt  = (c2_r == c3_r) ? c3_r : c_st_r; // same agreement test, 4 lines wide
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= PORT_RST; s2_r <= PORT_RST; s3_r <= PORT_RST; pa_st_r <= PORT_RST;
            t1_r <= PORT_RST; t2_r <= PORT_RST; t3_r <= PORT_RST; pb_st_r <= PORT_RST;
            c1_r <= 4'h0; c2_r <= 4'h0; c3_r <= 4'h0; c_st_r <= 4'h0;
        end
        else
        begin
            s1_r <= port_a_in; s2_r <= s1_r; s3_r <= s2_r; pa_st_r <= pa_st_nxt;
            t1_r <= port_b_in; t2_r <= t1_r; t3_r <= t2_r; pb_st_r <= pb_st_nxt;
            c1_r <= {port_b_second_control_line, port_b_strobe_input,
                     port_a_second_control_line, port_a_strobe_input};
            c2_r <= c1_r; c3_r <= c2_r; c_st_r <= c_st_nxt;
        end
    end

    // flag set events; edges set flags whatever the enables say
    always_comb
    begin
        set_ev = 7'h00;
        set_ev[IFB_A_STROBE]  = edge_hit(c_st_r[0], c_st_nxt[0], edge_polarity[0]);
        set_ev[IFB_A_SECOND]  = edge_hit(c_st_r[1], c_st_nxt[1], edge_polarity[1]);
        set_ev[IFB_B_STROBE]  = edge_hit(c_st_r[2], c_st_nxt[2], edge_polarity[2]);
        set_ev[IFB_B_SECOND]  = edge_hit(c_st_r[3], c_st_nxt[3], edge_polarity[3]);
        set_ev[IFB_SHIFTER]   = shifter_done;
        set_ev[IFB_TIMER_TWO] = timer_two_done;
        set_ev[IFB_TIMER_ONE] = timeout && armed_r;
    end

    // port latches; port a ignores direction, so outputs read back as pins
    acf_port_latch u_latch_a (
        .clock        (clock),
        .rst_n        (rst_n),
        .latch_enable (acr_r[ACB_PA_LATCH]),
        .capture      (set_ev[IFB_A_STROBE]),
        .hold         (ifr_r[IFB_A_STROBE]),
        .pin_level    (pa_st_r),
        .out_level    (ora_r),
        .direction    (8'h00),
        .latched      (pa_latch)
    );

    acf_port_latch u_latch_b (
        .clock        (clock),
        .rst_n        (rst_n),
        .latch_enable (acr_r[ACB_PB_LATCH]),
        .capture      (set_ev[IFB_B_STROBE]),
        .hold         (ifr_r[IFB_B_STROBE]),
        .pin_level    (pb_st_r),
        .out_level    (orb_r),
        .direction    (dirb_r),
        .latched      (pb_latch)
    );

    // timer_one: runs every cycle, latches feed only reloads and the start load
    always_comb
    begin
        timeout   = (cnt_r == TIMER_RST);
        cnt_nxt   = cnt_r - 16'h0001;
        lat_nxt   = lat_r;
        armed_nxt = armed_r;
        pb7_nxt   = pb7_r;
        if (timeout && acr_r[ACB_T1_FREE])
        begin
            cnt_nxt = lat_r;
            pb7_nxt = !pb7_r;
        end
        else if (timeout && armed_r)
        begin
            armed_nxt = 1'b0;                             // one-shot ends
            pb7_nxt   = 1'b1;
        end
        if (wr && (reg_select == OFS_T1_CNT_LO || reg_select == OFS_T1_LAT_LO))
            lat_nxt[7:0] = write_data;
        if (wr && reg_select == OFS_T1_LAT_HI)
            lat_nxt[15:8] = write_data;
        if (wr && reg_select == OFS_T1_CNT_HI)
        begin
            // start: high latch and full counter load, waveform goes low
            lat_nxt[15:8] = write_data;
            cnt_nxt       = {write_data, lat_r[7:0]};
            armed_nxt     = 1'b1;
            pb7_nxt       = 1'b0;
        end
    end

    // register writes, flags, enables, request and read data
    always_comb
    begin
        ora_nxt  = ora_r;
        orb_nxt  = orb_r;
        dira_nxt = dira_r;
        dirb_nxt = dirb_r;
        acr_nxt  = acr_r;
        ier_nxt  = ier_r;
        ifr_nxt  = ifr_r;
        if (wr)
        begin
            unique case (reg_select)
                OFS_PORT_B:      orb_nxt  = write_data;
                OFS_PORT_A:      ora_nxt  = write_data;
                OFS_DIR_B:       dirb_nxt = write_data;
                OFS_DIR_A:       dira_nxt = write_data;
                OFS_AUX_CONTROL: acr_nxt  = write_data;
                OFS_IRQ_FLAGS:   ifr_nxt  = ifr_r & ~write_data[6:0];
                OFS_IRQ_ENABLES:
                begin
                    if (write_data[IFB_ANY])
                        ier_nxt = ier_r | write_data[6:0];
                    else
                        ier_nxt = ier_r & ~write_data[6:0];
                end
                default: ;                                          // unmapped: ignored
            endcase
        end
        if (wr && reg_select == OFS_T1_CNT_HI)
            ifr_nxt[IFB_TIMER_ONE] = 1'b0;                  // restart acknowledges
        ifr_nxt   = ifr_nxt | set_ev;
        irq_n_nxt = ~|(ifr_nxt & ier_nxt);
        // read data, sampled at the access edge
        rd_nxt = 8'h00;
        if (rd)
        begin
            unique case (reg_select)
                OFS_PORT_B:      rd_nxt = pb_latch;
                OFS_PORT_A:      rd_nxt = pa_latch;
                OFS_DIR_B:       rd_nxt = dirb_r;
                OFS_DIR_A:       rd_nxt = dira_r;
                OFS_T1_CNT_LO:   rd_nxt = cnt_r[7:0];
                OFS_T1_CNT_HI:   rd_nxt = cnt_r[15:8];
                OFS_T1_LAT_LO:   rd_nxt = lat_r[7:0];
                OFS_T1_LAT_HI:   rd_nxt = lat_r[15:8];
                OFS_AUX_CONTROL: rd_nxt = acr_r;
                OFS_IRQ_FLAGS:   rd_nxt = {!irq_n_r, ifr_r};
                OFS_IRQ_ENABLES: rd_nxt = {1'b0, ier_r};
                default:         rd_nxt = 8'h00;
            endcase
        end
        // line seven overridden by timer_one when enabled
        pbo_nxt  = orb_nxt;
        pboe_nxt = dirb_nxt;
        if (acr_nxt[ACB_T1_OUT])
        begin
            pbo_nxt[7]  = pb7_nxt;
            pboe_nxt[7] = 1'b1;
        end
    end

    // single register stage for all of the above
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ora_r <= PORT_RST; orb_r <= PORT_RST; dira_r <= PORT_RST; dirb_r <= PORT_RST;
            acr_r <= AUX_CONTROL_RST; ifr_r <= IRQ_FLAGS_RST; ier_r <= IRQ_ENABLES_RST;
            cnt_r <= TIMER_RST; lat_r <= TIMER_RST; armed_r <= 1'b0; pb7_r <= 1'b1;
            rd_r  <= 8'h00; irq_n_r <= 1'b1; pbo_r <= PORT_RST; pboe_r <= PORT_RST;
        end
        else
        begin
            ora_r <= ora_nxt; orb_r <= orb_nxt; dira_r <= dira_nxt; dirb_r <= dirb_nxt;
            acr_r <= acr_nxt; ifr_r <= ifr_nxt; ier_r <= ier_nxt;
            cnt_r <= cnt_nxt; lat_r <= lat_nxt; armed_r <= armed_nxt; pb7_r <= pb7_nxt;
            rd_r  <= rd_nxt; irq_n_r <= irq_n_nxt; pbo_r <= pbo_nxt; pboe_r <= pboe_nxt;
        end
    end

    // outputs: all straight from flip-flops
    assign read_data              = rd_r;
    assign irq_n                  = irq_n_r;
    assign port_a_out             = ora_r;
    assign port_a_oe              = dira_r;
    assign port_b_out             = pbo_r;
    assign port_b_oe              = pboe_r;
    assign serial_shifter_mode    = acr_r[ACB_SHIFT_HI:ACB_SHIFT_LO];
    assign timer_two_count_pulses = acr_r[ACB_T2_MODE];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    pa_hold_a: assert property (acr_r[0] && ifr_r[1] && $past(ifr_r[1]) && !set_ev[1] |=>
        $stable(pa_latch)) else $error("port a latch moved while held");
    pa_follow_a: assert property (!acr_r[0] ##1 !acr_r[0] |->
        pa_latch == $past(pa_st_r)) else $error("port a latch not transparent");
    pa_read_a: assert property (rd && reg_select == OFS_PORT_A |=>
        read_data == $past(pa_latch)) else $error("port a read not from latch");
    pb_mix_a: assert property (!acr_r[1] ##1 !acr_r[1] |-> pb_latch ==
        (($past(pb_st_r) & ~$past(dirb_r)) | ($past(orb_r) & $past(dirb_r))))
        else $error("port b latch source wrong");
    shift_mode_a: assert property (wr && reg_select == OFS_AUX_CONTROL |=>
        serial_shifter_mode == $past(write_data[4:2])) else $error("shifter mode wrong");
    t2_mode_a: assert property (wr && reg_select == OFS_AUX_CONTROL |=>
        timer_two_count_pulses == $past(write_data[5])) else $error("timer two mode wrong");
    pb7_toggle_a: assert property (acr_r[7:6] == 2'b11 && timeout && !wr |=>
        port_b_out[7] != $past(port_b_out[7])) else $error("line seven not toggled");
    irq_merge_a: assert property (|(ifr_r & ier_r) |-> !irq_n)
        else $error("request missing for enabled flag");
    edge_set_a: assert property (set_ev[1] |=> ifr_r[1])
        else $error("edge flag not set");
    flag_clear_a: assert property (wr && reg_select == OFS_IRQ_FLAGS && write_data[5] &&
        !timer_two_done |=> !ifr_r[5]) else $error("flag not cleared");
    set_wins_a: assert property (wr && reg_select == OFS_IRQ_FLAGS && timer_two_done |=>
        ifr_r[5]) else $error("new flag lost on clear");
    reload_a: assert property (timeout && acr_r[6] && !(wr && reg_select == OFS_T1_CNT_HI)
        |=> cnt_r == $past(lat_r)) else $error("free-run reload missing");
    latch_wr_a: assert property (wr && reg_select == OFS_T1_LAT_HI && !timeout |=>
        cnt_r == $past(cnt_r) - 16'h0001) else $error("latch write disturbed count");
    ier_set_a: assert property (wr && reg_select == OFS_IRQ_ENABLES && write_data[7] |=>
        (ier_r & $past(write_data[6:0])) == $past(write_data[6:0]))
        else $error("enable not set");
    acr_rw_a: assert property (wr && reg_select == OFS_AUX_CONTROL ##1 rd &&
        reg_select == OFS_AUX_CONTROL |=> read_data == $past(write_data, 2))
        else $error("control register readback wrong");

    t1_fire_c: cover property (set_ev[IFB_TIMER_ONE]);
    irq_c:     cover property (irq_n_r ##1 !irq_n_r);
    pa_cap_c:  cover property (acr_r[0] && set_ev[1] ##2 ifr_r[1]);
endmodule
`default_nettype wire

// ===== bench/acf_host.sv
// acf_host: bus-side processor model issuing one-cycle register strobes.
// assumes its tasks are called one at a time by the bench.
`timescale 1ns/1ns
`default_nettype none
module acf_host
(
    input  wire logic       clock,
    output logic            chip_select,    // one-cycle access strobe
    output logic      [3:0] reg_select,     // register offset
    output logic            read_not_write, // 1 = read
    output logic      [7:0] write_data,     // write value
    input  wire logic [7:0] read_data       // answer right after the taking edge
);
    // idle bus from time zero
    initial
    begin
        chip_select = 1'b0;
        reg_select = 4'h0;
        read_not_write = 1'b1;
        write_data = 8'h00;
    end
    // write: held across exactly one taking edge, so no double take
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        {chip_select, reg_select, read_not_write, write_data} = {1'b1, a, 1'b0, d};
        @(posedge clock);
        #1;
        chip_select = 1'b0;
    endtask
    // read: data stands one cycle only, so it is taken right after that edge
    task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        {chip_select, reg_select, read_not_write} = {1'b1, a, 1'b1};
        @(posedge clock);
        #1;
        chip_select = 1'b0;
        d = read_data;
    endtask
endmodule
`default_nettype wire

// ===== bench/acf_aux_control_irq_flags_bench.sv
// acf_aux_control_irq_flags_bench: directed register-level tests.
// assumes the host model owns the bus; pins and done events driven here.
`timescale 1ns/1ns
`default_nettype none
module acf_aux_control_irq_flags_bench;
    import acf_pkg::*;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       chip_select, read_not_write;   // from the host model
    logic [3:0] reg_select;
    logic [7:0] write_data, read_data;
    logic       irq_n, a_strobe = 1'b0, b_strobe = 1'b0, a_second = 1'b0;
    logic [7:0] port_a_in = 8'h00, port_b_in = 8'h00;
    logic [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe;
    logic [3:0] edge_polarity = 4'h5;          // both strobes rising
    logic       shifter_done = 1'b0, timer_two_done = 1'b0;
    logic [2:0] serial_shifter_mode;
    logic       timer_two_count_pulses, last7;
    logic [7:0] v;                             // control value under test
    int         num_errors = 0, num_checks = 0, cyc = 0;
    int         tog[$];                        // cycles of line seven toggles
    always #2 clock = ~clock;
    acf_host i_acf_host (.clock(clock), .chip_select(chip_select),
        .reg_select(reg_select), .read_not_write(read_not_write),
        .write_data(write_data), .read_data(read_data));
    acf_aux_control_irq_flags i_acf_aux_control_irq_flags (.clock(clock), .rst_n(rst_n),
        .chip_select(chip_select), .reg_select(reg_select),
        .read_not_write(read_not_write), .write_data(write_data), .read_data(read_data),
        .irq_n(irq_n), .port_a_in(port_a_in), .port_a_out(port_a_out),
        .port_a_oe(port_a_oe), .port_b_in(port_b_in), .port_b_out(port_b_out),
        .port_b_oe(port_b_oe), .port_a_strobe_input(a_strobe),
        .port_a_second_control_line(a_second), .port_b_strobe_input(b_strobe),
        .port_b_second_control_line(1'b0), .edge_polarity(edge_polarity),
        .shifter_done(shifter_done), .timer_two_done(timer_two_done),
        .serial_shifter_mode(serial_shifter_mode),
        .timer_two_count_pulses(timer_two_count_pulses));
    // cycle count, toggle log and hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (port_b_out[7] !== last7)
            tog.push_back(cyc);
        last7 = port_b_out[7];
        if (cyc == 20000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        i_acf_host.bus_read(a, d);
        check8(name, exp, d);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_acf_host.bus_write(a, d);
    endtask
    // pins pass a 3-stage synchroniser, so give them time to land
    task automatic settle();
        repeat (8) @(posedge clock);
        #1;
    endtask
    // one-cycle done events: [1] timer two, [0] shifter
    task automatic pulse(input logic [1:0] w);
        @(posedge clock);
        #1;
        {timer_two_done, shifter_done} = w;
        @(posedge clock);
        #1;
        {timer_two_done, shifter_done} = 2'b00;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        check8("irq_n", 8'h01, {7'h00, irq_n});
        rd(OFS_AUX_CONTROL, AUX_CONTROL_RST, "control");
        rd(OFS_IRQ_FLAGS, 8'h00, "flags");
        rd(OFS_IRQ_ENABLES, 8'h00, "enables");
        wr(4'h8, 8'hff);
        rd(4'h8, 8'h00, "unmapped");
        // every shifter mode, both timer two modes
        for (int i = 0; i < 8; i++)
        begin
            v = {2'b00, i[0], i[2:0], 2'b00};
            wr(OFS_AUX_CONTROL, v);
            rd(OFS_AUX_CONTROL, v, "control");
            check8("shift_mode", {5'h00, i[2:0]}, {5'h00, serial_shifter_mode});
            check8("t2_mode", {7'h00, i[0]}, {7'h00, timer_two_count_pulses});
        end
        $display("test control done");
        pulse(2'b01);
        rd(OFS_IRQ_FLAGS, 8'h04, "flags");
        check8("irq_n", 8'h01, {7'h00, irq_n});
        wr(OFS_IRQ_ENABLES, 8'h84);
        @(posedge clock);
        #1;
        check8("irq_n", 8'h00, {7'h00, irq_n});
        rd(OFS_IRQ_FLAGS, 8'h84, "flags");
        rd(OFS_IRQ_ENABLES, 8'h04, "enables");
        wr(OFS_IRQ_ENABLES, 8'h04);
        rd(OFS_IRQ_ENABLES, 8'h00, "enables");
        check8("irq_n", 8'h01, {7'h00, irq_n});
        // clear and new set land on the same edge
        fork
            wr(OFS_IRQ_FLAGS, 8'h24);
            pulse(2'b11);
        join
        rd(OFS_IRQ_FLAGS, 8'h24, "flags");
        wr(OFS_IRQ_FLAGS, 8'h04);
        rd(OFS_IRQ_FLAGS, 8'h20, "flags");
        wr(OFS_IRQ_FLAGS, 8'h20);
        rd(OFS_IRQ_FLAGS, 8'h00, "flags");
        $display("test flags done");
        // port a: output pins still read back the pins
        wr(OFS_AUX_CONTROL, 8'h00);
        wr(OFS_DIR_A, 8'hff);
        wr(OFS_PORT_A, 8'h0f);
        port_a_in = 8'ha5;
        settle();
        rd(OFS_PORT_A, 8'ha5, "port_a");
        check8("port_a_out", 8'h0f, port_a_out);
        check8("port_a_oe", 8'hff, port_a_oe);
        wr(OFS_DIR_A, 8'h00);
        wr(OFS_AUX_CONTROL, 8'h01);
        port_a_in = 8'h3c;
        a_second = 1'b1;
        settle();
        a_strobe = 1'b1;
        settle();
        port_a_in = 8'hc3;
        a_second = 1'b0;
        settle();
        rd(OFS_PORT_A, 8'h3c, "port_a");
        rd(OFS_IRQ_FLAGS, 8'h03, "flags");
        wr(OFS_AUX_CONTROL, 8'h00);
        settle();
        rd(OFS_PORT_A, 8'hc3, "port_a");
        $display("test port_a done");
        // port b: output bits latch the output register
        wr(OFS_DIR_B, 8'h0f);
        wr(OFS_PORT_B, 8'h05);
        wr(OFS_AUX_CONTROL, 8'h02);
        port_b_in = 8'ha0;
        settle();
        b_strobe = 1'b1;
        settle();
        port_b_in = 8'h50;
        wr(OFS_PORT_B, 8'h0a);
        settle();
        rd(OFS_PORT_B, 8'ha5, "port_b");
        wr(OFS_AUX_CONTROL, 8'h00);
        settle();
        rd(OFS_PORT_B, 8'h5a, "port_b");
        $display("test port_b done");
        // timer one free run on line seven, latch changed mid-count
        wr(OFS_T1_LAT_LO, 8'h10);
        wr(OFS_T1_LAT_HI, 8'h00);
        wr(OFS_AUX_CONTROL, 8'hc0);
        settle();
        check8("line7_oe", 8'h01, {7'h00, port_b_oe[7]});
        check8("port_b_oe", 8'h8f, port_b_oe);
        tog.delete();
        wr(OFS_T1_CNT_HI, 8'h00);
        while (tog.size() < 3)
            @(posedge clock);
        wr(OFS_T1_LAT_LO, 8'h08);
        while (tog.size() < 6)
            @(posedge clock);
        check8("period", 8'h11, 8'(tog[1] - tog[0]));
        check8("period", 8'h11, 8'(tog[2] - tog[1]));
        check8("period", 8'h11, 8'(tog[3] - tog[2]));
        check8("period", 8'h09, 8'(tog[4] - tog[3]));
        check8("period", 8'h09, 8'(tog[5] - tog[4]));
        $display("test timer_one done");
        close_out();
    end
endmodule
`default_nettype wire
